// ---- hw/fsp_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the fast serial port
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// Printed offsets are not all multiples of four: these are indices, byte address = 4 * index
`define FSP_IDX_CTRL        16'hC070
`define FSP_IDX_BAUD        16'hC072
`define FSP_IDX_GAP         16'hC074
`define FSP_IDX_DATA        16'hC076
`define FSP_IDX_RX_BASE     16'hC078
`define FSP_IDX_RX_COUNT    16'hC07A
`define FSP_IDX_TX_BASE     16'hC07C
`define FSP_IDX_TX_COUNT    16'hC07E

`define FSP_CTRL_ENABLE     15
`define FSP_CTRL_TX_DONE    7
`define FSP_CTRL_RX_DONE    6
`define FSP_CTRL_ONE_STOP   5
`define FSP_CTRL_TX_READY   4
`define FSP_CTRL_RX_OVF     2
`define FSP_CTRL_RX_READY   0

`define FSP_BAUD_RESET      13'h0017
`define FSP_GAP_RESET       8'h09
`define FSP_GAP_OFFSET      8'h07
`define FSP_COUNT_DONE      10'h3FF
`define FSP_COUNT_RESET     10'h000
`define FSP_BASE_RESET      16'h0000

`endif

// ---- hw/fsp_pkg.sv ----
// Types shared by the fast serial port design files
package fsp_pkg;
    typedef enum logic [1:0] {FSP_TX_IDLE, FSP_TX_START, FSP_TX_DATA, FSP_TX_STOP} fsp_tx_state_t;
    typedef enum logic [1:0] {FSP_RX_IDLE, FSP_RX_START, FSP_RX_DATA, FSP_RX_STOP} fsp_rx_state_t;
    typedef enum logic [1:0] {FSP_BLK_IDLE, FSP_BLK_FETCH, FSP_BLK_WAIT, FSP_BLK_SEND} fsp_blk_state_t;
    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } fsp_mem_req_t;
endpackage : fsp_pkg

// ---- hw/fsp_mem.sv ----
// Byte buffer memory for block transfers, registered read data
`timescale 1ns/1ps
`default_nettype none
module fsp_mem
    import fsp_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    // Clock
    input  wire logic         clk,
    // Access port
    input  wire fsp_mem_req_t req,
    input  wire logic         en,
    output logic [7:0]        rdata
);
    logic [7:0] store [0:(1<<ADDR_W)-1];

    // No reset on the array so it maps onto block RAM
    always_ff @(posedge clk) begin
        if (en && req.we) begin
            store[req.addr[ADDR_W-1:0]] <= req.wdata;
        end
        if (en) begin
            rdata <= store[req.addr[ADDR_W-1:0]];
        end
    end
endmodule : fsp_mem
`default_nettype wire

// ---- hw/fsp_top.sv ----
// Fast serial port: APB registers, byte and block transmit and receive
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.svh"

// Behaviour
// - Gap setting replaces stop bits in block transmit
// - Gap register resets to 0x0009
// - Idle time is gap minus seven bits
// - Data read returns last byte received outside block receive
// - Data write sends one byte; ignored while transmitter busy or in block transmit
// - Receive base pointer sets block receive start address
// - Transmit base pointer sets block transmit start address
// - Loading receive counter starts block receive
// - Receive counter decrements per received byte
// - Loading transmit counter starts block transmit
// - Transmit counter decrements per sent byte
// - Counters are ten bits, max 0x3FF
// - Finished counter reads 0x3FF until reloaded
// - Transmit done sets at end, write-one clears
// - Receive ready shows non-empty receive holding
// - One-stop bit selects stop count; receiver flexible
// - Bit rate is clock over divisor plus one
module fsp_top
    import fsp_pkg::*;
#(
    parameter int MEM_AW = 10
) (
    // APB
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [19:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link
    input  wire logic        rx_in,
    output logic             tx_out
);
    localparam logic [19:0] A_CTRL  = 20'(`FSP_IDX_CTRL * 4);
    localparam logic [19:0] A_BAUD  = 20'(`FSP_IDX_BAUD * 4);
    localparam logic [19:0] A_GAP   = 20'(`FSP_IDX_GAP * 4);
    localparam logic [19:0] A_DATA  = 20'(`FSP_IDX_DATA * 4);
    localparam logic [19:0] A_RXB   = 20'(`FSP_IDX_RX_BASE * 4);
    localparam logic [19:0] A_RXC   = 20'(`FSP_IDX_RX_COUNT * 4);
    localparam logic [19:0] A_TXB   = 20'(`FSP_IDX_TX_BASE * 4);
    localparam logic [19:0] A_TXC   = 20'(`FSP_IDX_TX_COUNT * 4);

    logic        enable_r;
    logic        one_stop_r;
    logic        tx_done_r;
    logic        rx_done_r;
    logic        rx_ovf_r;
    logic [12:0] baud_r;
    logic [7:0]  gap_r;
    logic [15:0] rx_base_r;
    logic [15:0] tx_base_r;
    logic [9:0]  rx_cnt_r;
    logic [9:0]  tx_cnt_r;
    logic        rx_blk_r;
    logic        tx_blk_r;
    logic [7:0]  rx_data_r;
    logic        rx_ready_r;

    // Transmitter
    fsp_tx_state_t  tx_st_r;
    logic [12:0] tx_div_r;
    logic [2:0]  tx_bit_r;
    logic [8:0]  tx_stop_r;
    logic [7:0]  tx_sh_r;
    logic        tx_tick;
    logic        tx_busy;
    logic        tx_load;
    logic [7:0]  tx_load_data;
    logic        tx_byte_done;

    // Receiver
    fsp_rx_state_t  rx_st_r;
    logic [12:0] rx_div_r;
    logic [2:0]  rx_bit_r;
    logic [7:0]  rx_sh_r;
    logic        rx_tick;
    logic        rx_byte_done;

    // Block transmit sequencer, block pointers and memory
    fsp_blk_state_t blk_st_r;
    logic [15:0]  tx_ptr_r;
    logic [15:0]  rx_ptr_r;
    fsp_mem_req_t mem_req;
    logic         mem_en;
    logic [7:0]   mem_rdata;
    logic         rx_mem_wr;

    logic wr_acc;
    logic rd_acc;
    logic data_wr;
    logic ctrl_wr;
    logic rxc_wr;
    logic txc_wr;

    function automatic logic [12:0] half_bit(input logic [12:0] div);
        return {1'b0, div[12:1]};
    endfunction : half_bit

    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && penable && !pwrite;
    assign data_wr = wr_acc && paddr == A_DATA && pstrb[0];
    assign ctrl_wr = wr_acc && paddr == A_CTRL;
    assign rxc_wr  = wr_acc && paddr == A_RXC && pstrb[0];
    assign txc_wr  = wr_acc && paddr == A_TXC && pstrb[0];
    assign pready  = 1'b1;

    // Zero-wait slave; unmapped addresses answer with an error
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            unique case (paddr)
                A_CTRL, A_BAUD, A_GAP, A_DATA, A_RXB, A_RXC, A_TXB, A_TXC: pslverr = 1'b0;
                default: pslverr = 1'b1;
            endcase
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            A_CTRL: begin
                prdata[`FSP_CTRL_ENABLE]   = enable_r;
                prdata[`FSP_CTRL_TX_DONE]  = tx_done_r;
                prdata[`FSP_CTRL_RX_DONE]  = rx_done_r;
                prdata[`FSP_CTRL_ONE_STOP] = one_stop_r;
                prdata[`FSP_CTRL_TX_READY] = !tx_busy && !tx_blk_r;
                prdata[`FSP_CTRL_RX_OVF]   = rx_ovf_r;
                prdata[`FSP_CTRL_RX_READY] = rx_ready_r;
            end
            A_BAUD:  prdata[12:0] = baud_r;
            A_GAP:   prdata[7:0]  = gap_r;
            A_DATA:  prdata[7:0]  = rx_data_r;
            A_RXB:   prdata[15:0] = rx_base_r;
            A_RXC:   prdata[9:0]  = rx_cnt_r;
            A_TXB:   prdata[15:0] = tx_base_r;
            A_TXC:   prdata[9:0]  = tx_cnt_r;
            default: prdata = 32'h0000_0000;
        endcase
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r   <= 1'b0;
            one_stop_r <= 1'b0;
            baud_r     <= `FSP_BAUD_RESET;
            gap_r      <= `FSP_GAP_RESET;
            rx_base_r  <= `FSP_BASE_RESET;
            tx_base_r  <= `FSP_BASE_RESET;
        end else if (wr_acc) begin
            unique case (paddr)
                A_CTRL: begin
                    if (pstrb[1]) enable_r <= pwdata[`FSP_CTRL_ENABLE];
                    if (pstrb[0]) one_stop_r <= pwdata[`FSP_CTRL_ONE_STOP];
                end
                A_BAUD: begin
                    if (pstrb[0]) baud_r[7:0] <= pwdata[7:0];
                    if (pstrb[1]) baud_r[12:8] <= pwdata[12:8];
                end
                A_GAP: if (pstrb[0]) gap_r <= pwdata[7:0];
                A_RXB: begin
                    if (pstrb[0]) rx_base_r[7:0] <= pwdata[7:0];
                    if (pstrb[1]) rx_base_r[15:8] <= pwdata[15:8];
                end
                A_TXB: begin
                    if (pstrb[0]) tx_base_r[7:0] <= pwdata[7:0];
                    if (pstrb[1]) tx_base_r[15:8] <= pwdata[15:8];
                end
                default: ;
            endcase
        end
    end

    // Status flags: a hardware set wins over a software write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_done_r <= 1'b0;
            rx_done_r <= 1'b0;
            rx_ovf_r  <= 1'b0;
        end else begin
            if (tx_blk_r && tx_byte_done && tx_cnt_r == 10'h000) tx_done_r <= 1'b1;
            else if (ctrl_wr && pstrb[0] && pwdata[`FSP_CTRL_TX_DONE]) tx_done_r <= 1'b0;
            if (rx_blk_r && rx_byte_done && rx_cnt_r == 10'h000) rx_done_r <= 1'b1;
            else if (ctrl_wr && pstrb[0] && pwdata[`FSP_CTRL_RX_DONE]) rx_done_r <= 1'b0;
            if (!rx_blk_r && rx_byte_done && rx_ready_r) rx_ovf_r <= 1'b1;
            else if (ctrl_wr && pstrb[0] && pwdata[`FSP_CTRL_RX_OVF]) rx_ovf_r <= 1'b0;
        end
    end

    // Block receive counter and pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt_r <= `FSP_COUNT_RESET;
            rx_blk_r <= 1'b0;
            rx_ptr_r <= `FSP_BASE_RESET;
        end else if (rxc_wr) begin
            rx_cnt_r <= {pwdata[9:8] & {2{pstrb[1]}}, pwdata[7:0]};
            rx_blk_r <= 1'b1;
            rx_ptr_r <= rx_base_r;
        end else if (rx_blk_r && rx_byte_done) begin
            rx_ptr_r <= rx_ptr_r + 16'h0001;
            rx_cnt_r <= rx_cnt_r - 10'h001;
            if (rx_cnt_r == 10'h000) rx_blk_r <= 1'b0;
        end
    end

    // Single-byte receive holding register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_r  <= 8'h00;
            rx_ready_r <= 1'b0;
        end else if (!rx_blk_r && rx_byte_done) begin
            rx_data_r  <= rx_sh_r;
            rx_ready_r <= 1'b1;
        end else if (rd_acc && paddr == A_DATA) begin
            rx_ready_r <= 1'b0;
        end
    end

    // Block transmit counter, pointer and fetch sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt_r <= `FSP_COUNT_RESET;
            tx_blk_r <= 1'b0;
            tx_ptr_r <= `FSP_BASE_RESET;
            blk_st_r <= FSP_BLK_IDLE;
        end else if (txc_wr) begin
            tx_cnt_r <= {pwdata[9:8] & {2{pstrb[1]}}, pwdata[7:0]};
            tx_blk_r <= 1'b1;
            tx_ptr_r <= tx_base_r;
            blk_st_r <= FSP_BLK_FETCH;
        end else begin
            unique case (blk_st_r)
                FSP_BLK_IDLE: ;
                FSP_BLK_FETCH: if (!tx_busy && !rx_mem_wr) blk_st_r <= FSP_BLK_WAIT;
                FSP_BLK_WAIT: blk_st_r <= FSP_BLK_SEND;
                FSP_BLK_SEND: begin
                    if (tx_byte_done) begin
                        tx_ptr_r <= tx_ptr_r + 16'h0001;
                        tx_cnt_r <= tx_cnt_r - 10'h001;
                        if (tx_cnt_r == 10'h000) begin
                            tx_blk_r <= 1'b0;
                            blk_st_r <= FSP_BLK_IDLE;
                        end else begin
                            blk_st_r <= FSP_BLK_FETCH;
                        end
                    end
                end
            endcase
        end
    end

    // Memory: receive writes take priority over transmit fetches
    assign rx_mem_wr     = rx_blk_r && rx_byte_done;
    assign mem_en        = rx_mem_wr || (blk_st_r == FSP_BLK_FETCH && !tx_busy);
    assign mem_req.we    = rx_mem_wr;
    assign mem_req.addr  = rx_mem_wr ? rx_ptr_r : tx_ptr_r;
    assign mem_req.wdata = rx_sh_r;

    fsp_mem #(
        .ADDR_W (MEM_AW)
    ) u_mem (
        .clk   (pclk),
        .req   (mem_req),
        .en    (mem_en),
        .rdata (mem_rdata)
    );

    // Transmit start sources
    assign tx_load      = enable_r && ((data_wr && !tx_blk_r && !tx_busy) || (blk_st_r == FSP_BLK_WAIT));
    assign tx_load_data = (blk_st_r == FSP_BLK_WAIT) ? mem_rdata : pwdata[7:0];
    assign tx_busy      = tx_st_r != FSP_TX_IDLE;

    // Bit-rate divider, one enable pulse per bit time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_div_r <= 13'h0000;
        end else if (tx_load || tx_div_r == 13'h0000) begin
            tx_div_r <= baud_r;
        end else begin
            tx_div_r <= tx_div_r - 13'h0001;
        end
    end
    assign tx_tick = tx_busy && tx_div_r == 13'h0000;

    // Transmit shifter; stop-period length counted in bit times
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_r   <= FSP_TX_IDLE;
            tx_out    <= 1'b1;
            tx_sh_r   <= 8'h00;
            tx_bit_r  <= 3'h0;
            tx_stop_r <= 9'h000;
        end else begin
            unique case (tx_st_r)
                FSP_TX_IDLE: begin
                    tx_out <= 1'b1;
                    if (tx_load) begin
                        tx_sh_r <= tx_load_data;
                        tx_st_r <= FSP_TX_START;
                        tx_out  <= 1'b0;
                    end
                end
                FSP_TX_START: if (tx_tick) begin
                    tx_out   <= tx_sh_r[0];
                    tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
                    tx_bit_r <= 3'h0;
                    tx_st_r  <= FSP_TX_DATA;
                end
                FSP_TX_DATA: if (tx_tick) begin
                    if (tx_bit_r == 3'h7) begin
                        tx_out  <= 1'b1;
                        tx_st_r <= FSP_TX_STOP;
                        if (tx_blk_r) begin
                            // Gap below 8 would mean no stop bit; clamp to one
                            tx_stop_r <= (gap_r > `FSP_GAP_OFFSET) ?
                                         {1'b0, gap_r - `FSP_GAP_OFFSET} : 9'h001;
                        end else begin
                            tx_stop_r <= one_stop_r ? 9'h001 : 9'h002;
                        end
                    end else begin
                        tx_out   <= tx_sh_r[0];
                        tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
                        tx_bit_r <= tx_bit_r + 3'h1;
                    end
                end
                FSP_TX_STOP: if (tx_tick) begin
                    if (tx_stop_r == 9'h001) tx_st_r <= FSP_TX_IDLE;
                    tx_stop_r <= tx_stop_r - 9'h001;
                end
            endcase
        end
    end
    assign tx_byte_done = tx_tick && tx_st_r == FSP_TX_STOP && tx_stop_r == 9'h001;

    // Receiver: samples mid-bit, needs only one stop bit, so any longer idle is accepted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_r  <= FSP_RX_IDLE;
            rx_div_r <= 13'h0000;
            rx_bit_r <= 3'h0;
            rx_sh_r  <= 8'h00;
        end else begin
            unique case (rx_st_r)
                FSP_RX_IDLE: if (enable_r && !rx_in) begin
                    rx_div_r <= half_bit(baud_r);
                    rx_st_r  <= FSP_RX_START;
                end
                FSP_RX_START: if (rx_tick) begin
                    rx_div_r <= baud_r;
                    rx_bit_r <= 3'h0;
                    rx_st_r  <= rx_in ? FSP_RX_IDLE : FSP_RX_DATA;
                end else begin
                    rx_div_r <= rx_div_r - 13'h0001;
                end
                FSP_RX_DATA: if (rx_tick) begin
                    rx_div_r <= baud_r;
                    rx_sh_r  <= {rx_in, rx_sh_r[7:1]};
                    rx_bit_r <= rx_bit_r + 3'h1;
                    if (rx_bit_r == 3'h7) rx_st_r <= FSP_RX_STOP;
                end else begin
                    rx_div_r <= rx_div_r - 13'h0001;
                end
                FSP_RX_STOP: if (rx_tick) begin
                    rx_st_r <= FSP_RX_IDLE;
                end else begin
                    rx_div_r <= rx_div_r - 13'h0001;
                end
            endcase
        end
    end
    assign rx_tick      = rx_st_r != FSP_RX_IDLE && rx_div_r == 13'h0000;
    assign rx_byte_done = rx_tick && rx_st_r == FSP_RX_STOP && rx_in;
endmodule : fsp_top
`default_nettype wire

// ---- bench/fsp_monitor.sv ----
// Port-level property checker for the fast serial port, bound into fsp_top
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.svh"
module fsp_monitor
    import fsp_pkg::*;
#(
    parameter int MEM_AW = 10
) (
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [19:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Serial link
    input wire logic        rx_in,
    input wire logic        tx_out
);
    localparam logic [19:0] A_BAUD = {2'b00, `FSP_IDX_BAUD, 2'b00};
    localparam logic [19:0] A_GAP  = {2'b00, `FSP_IDX_GAP, 2'b00};
    localparam logic [19:0] A_DATA = {2'b00, `FSP_IDX_DATA, 2'b00};
    localparam logic [19:0] A_RXB  = {2'b00, `FSP_IDX_RX_BASE, 2'b00};
    localparam logic [19:0] A_RXC  = {2'b00, `FSP_IDX_RX_COUNT, 2'b00};
    localparam logic [19:0] A_TXB  = {2'b00, `FSP_IDX_TX_BASE, 2'b00};
    localparam logic [19:0] A_TXC  = {2'b00, `FSP_IDX_TX_COUNT, 2'b00};
    localparam logic [19:0] A_CTRL = {2'b00, `FSP_IDX_CTRL, 2'b00};
    logic        rd;
    logic        wr;
    logic [7:0]  gap_m;
    logic [12:0] baud_m;
    logic [15:0] rxb_m;
    logic [15:0] txb_m;
    logic        en_m;
    logic [15:0] low_cnt;
    logic [15:0] hi_cnt;
    logic [15:0] bit_len;
    assign rd = psel && penable && !pwrite;
    assign wr = psel && penable && pwrite && pready;
    assign bit_len = {3'b000, baud_m} + 16'h0001;
    // Mirrors assume full lane strobes, as the bench always gives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_m <= `FSP_GAP_RESET;
            baud_m <= `FSP_BAUD_RESET;
            rxb_m <= `FSP_BASE_RESET;
            txb_m <= `FSP_BASE_RESET;
            en_m <= 1'b0;
        end else if (wr) begin
            if (paddr == A_GAP) gap_m <= pwdata[7:0];
            if (paddr == A_BAUD) baud_m <= pwdata[12:0];
            if (paddr == A_RXB) rxb_m <= pwdata[15:0];
            if (paddr == A_TXB) txb_m <= pwdata[15:0];
            if (paddr == A_CTRL) en_m <= pwdata[`FSP_CTRL_ENABLE];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= 16'h0000;
            hi_cnt <= 16'h0000;
        end else begin
            low_cnt <= tx_out ? 16'h0000 : low_cnt + 16'h0001;
            hi_cnt <= !tx_out ? 16'h0000 : (hi_cnt == 16'hFFFF ? hi_cnt : hi_cnt + 16'h0001);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_gap_readback: assert property (rd && paddr == A_GAP |-> prdata == {24'h0, gap_m})
        else $error("gap register readback wrong");
    a_baud_readback: assert property (rd && paddr == A_BAUD |-> prdata == {19'h0, baud_m})
        else $error("baud register readback wrong");
    a_rx_base_read: assert property (rd && paddr == A_RXB |-> prdata == {16'h0, rxb_m})
        else $error("receive base readback wrong");
    a_tx_base_read: assert property (rd && paddr == A_TXB |-> prdata == {16'h0, txb_m})
        else $error("transmit base readback wrong");
    a_count_width: assert property (rd && (paddr == A_RXC || paddr == A_TXC) |-> prdata[31:10] == 22'h0)
        else $error("counter wider than ten bits");
    a_data_width: assert property (rd && paddr == A_DATA |-> prdata[31:8] == 24'h0)
        else $error("data read wider than a byte");
    a_byte_start: assert property (wr && paddr == A_DATA && en_m && hi_cnt > 3 * bit_len |=> !tx_out [*2])
        else $error("byte write did not start a frame");
    a_low_limit: assert property (low_cnt <= 9 * bit_len)
        else $error("line low longer than start plus eight bits");
    c_data_write: cover property (wr && paddr == A_DATA);
    c_frame_start: cover property ($fell(tx_out));
    c_count_done: cover property (rd && paddr == A_TXC && prdata[9:0] == 10'h3FF);
endmodule : fsp_monitor

bind fsp_top fsp_monitor #(.MEM_AW(MEM_AW)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out)
);
`default_nettype wire

// ---- bench/fsp_link_peer.sv ----
// Far-end serial device: decodes the transmit line, drives the receive line
`timescale 1ns/1ps
`default_nettype none
module fsp_link_peer (
    // Clock and bit length in clock cycles
    input  wire logic        clk,
    input  wire logic [15:0] bit_cyc,
    // Serial lines
    input  wire logic        line_in,
    output logic             line_out
);
    logic [7:0] got[$];
    int         span[$];
    int         cyc = 0;
    int         last_fall = -1;
    initial line_out = 1'b1;
    always @(posedge clk) cyc <= cyc + 1;
    // Mid-bit sampling: first data bit read one and a half bit times after the falling edge
    always begin : rx_decode
        logic [7:0] b;
        @(negedge line_in);
        if (last_fall >= 0) span.push_back(cyc - last_fall);
        last_fall = cyc;
        repeat (bit_cyc / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge clk);
            b[i] = line_in;
        end
        got.push_back(b);
        repeat (bit_cyc) @(posedge clk);
    end
    // Called just after a rising edge; idle level is high
    task automatic send_byte(input logic [7:0] b, input int stops);
        logic [10:0] f;
        f = {2'b11, b, 1'b0};
        for (int i = 0; i < 9 + stops; i++) begin
            line_out <= f[i];
            repeat (bit_cyc) @(posedge clk);
        end
    endtask : send_byte
endmodule : fsp_link_peer
`default_nettype wire

// ---- bench/test_fast_serial_block_transfer.sv ----
// Self-checking bench for the fast serial port
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.svh"
module test_fast_serial_block_transfer;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [19:0] paddr   = 20'h00000;
    logic [31:0] pwdata  = 32'h00000000;
    logic [3:0]  pstrb   = 4'hF;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_in;
    logic        tx_out;
    logic [15:0] bit_cyc = 16'h0018;
    logic [31:0] rd_v;
    logic        err_v;
    int          n_fail = 0;
    int          checks = 0;
    int          cyc    = 0;
    always #2 pclk = ~pclk;
    fsp_top #(.MEM_AW(10)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out)
    );
    fsp_link_peer u_peer (.clk(pclk), .bit_cyc(bit_cyc), .line_in(tx_out), .line_out(rx_in));
    task automatic close_out;
        $display("checks %0d errors %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            close_out();
        end
    end
    // Entered just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_flag(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, `FSP_IDX_CTRL, 32'h0);
            n++;
        end while (rd_v[b] !== v && n < 3000);
        check("ctrl flag", {31'h0, rd_v[b]}, {31'h0, v});
    endtask : wait_flag
    initial begin
        int t0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `FSP_IDX_GAP, 32'h0);
        check("gap reset", rd_v, 32'h9);
        apb(1'b0, `FSP_IDX_RX_COUNT, 32'h0);
        check("rx count reset", rd_v, 32'h0);
        apb(1'b0, `FSP_IDX_TX_BASE, 32'h0);
        check("tx base reset", rd_v, 32'h0);
        apb(1'b0, 16'hC080, 32'h0);
        check("unmapped error", {31'h0, err_v}, 32'h1);
        apb(1'b1, `FSP_IDX_CTRL, 32'h8000);
        wait_flag(`FSP_CTRL_TX_READY, 1'b1);
        t0 = cyc;
        apb(1'b1, `FSP_IDX_DATA, 32'hA5);
        apb(1'b1, `FSP_IDX_DATA, 32'h5A);
        wait_flag(`FSP_CTRL_TX_READY, 1'b1);
        check("two stop frame bits", (cyc - t0 + 12) / 24, 11);
        check("byte count", u_peer.got.size(), 1);
        check("byte value", u_peer.got.pop_front(), 32'hA5);
        bit_cyc = 16'h0020;
        apb(1'b1, `FSP_IDX_BAUD, 32'h1F);
        apb(1'b0, `FSP_IDX_BAUD, 32'h0);
        check("baud", rd_v, 32'h1F);
        apb(1'b1, `FSP_IDX_GAP, 32'h0C);
        apb(1'b1, `FSP_IDX_CTRL, 32'h8020);
        t0 = cyc;
        apb(1'b1, `FSP_IDX_DATA, 32'h3C);
        wait_flag(`FSP_CTRL_TX_READY, 1'b1);
        check("one stop frame bits", (cyc - t0 + 16) / 32, 10);
        check("byte at new rate", u_peer.got.pop_front(), 32'h3C);
        u_peer.send_byte(8'hC3, 1);
        repeat (8) @(posedge pclk);
        apb(1'b0, `FSP_IDX_CTRL, 32'h0);
        check("rx ready set", rd_v[`FSP_CTRL_RX_READY], 1);
        apb(1'b0, `FSP_IDX_DATA, 32'h0);
        check("rx byte", rd_v, 32'hC3);
        apb(1'b0, `FSP_IDX_CTRL, 32'h0);
        check("rx ready clear", rd_v[`FSP_CTRL_RX_READY], 0);
        apb(1'b1, `FSP_IDX_RX_BASE, 32'h10);
        apb(1'b1, `FSP_IDX_RX_COUNT, 32'h2);
        u_peer.send_byte(8'h11, 1);
        repeat (8) @(posedge pclk);
        apb(1'b0, `FSP_IDX_RX_COUNT, 32'h0);
        check("rx count left", rd_v, 32'h1);
        u_peer.send_byte(8'h22, 2);
        u_peer.send_byte(8'h33, 1);
        repeat (8) @(posedge pclk);
        apb(1'b0, `FSP_IDX_RX_COUNT, 32'h0);
        check("rx count done", rd_v, 32'h3FF);
        apb(1'b0, `FSP_IDX_CTRL, 32'h0);
        check("rx done set", rd_v[`FSP_CTRL_RX_DONE], 1);
        u_peer.last_fall = -1;
        u_peer.span.delete();
        apb(1'b1, `FSP_IDX_TX_BASE, 32'h10);
        apb(1'b1, `FSP_IDX_TX_COUNT, 32'h2);
        t0 = 0;
        while (u_peer.got.size() < 1 && t0 < 3000) begin
            t0++;
            @(posedge pclk);
        end
        // Past the first byte's last stop bit, inside the second frame
        repeat (256) @(posedge pclk);
        apb(1'b0, `FSP_IDX_TX_COUNT, 32'h0);
        check("tx count left", rd_v, 32'h1);
        wait_flag(`FSP_CTRL_TX_DONE, 1'b1);
        apb(1'b0, `FSP_IDX_TX_COUNT, 32'h0);
        check("tx count done", rd_v, 32'h3FF);
        check("block bytes", {u_peer.got[0], u_peer.got[1], u_peer.got[2]}, 32'h112233);
        check("gap frame bits", (u_peer.span[0] + 16) / 32, 14);
        apb(1'b1, `FSP_IDX_CTRL, 32'h80A0);
        apb(1'b0, `FSP_IDX_CTRL, 32'h0);
        check("tx done clear", rd_v[`FSP_CTRL_TX_DONE], 0);
        close_out();
    end
endmodule : test_fast_serial_block_transfer
`default_nettype wire
